//--- include/gadvr_params.svh
// Offsets, field positions, reset values and codes of the alignment/volume register bank
`ifndef GADVR_PARAMS_SVH
`define GADVR_PARAMS_SVH
// Register indices; byte address is four times the index
`define GADVR_IDX_PIN     6'h15
`define GADVR_IDX_AUDIO   6'h16
`define GADVR_IDX_ALIGN   6'h17
`define GADVR_IDX_SLOTS   6'h18
`define GADVR_IDX_DIAG    6'h19
`define GADVR_IDX_VOL     6'h1A
// Reset values
`define GADVR_RST_PIN     3'h0
`define GADVR_RST_AUDIO   8'h12
`define GADVR_RST_ALIGN   8'h0C
`define GADVR_RST_SLOTS   8'h00
`define GADVR_RST_DIAG    8'h0D
`define GADVR_RST_VOL     8'h00
// Field positions
`define GADVR_PIN_LSB     2
`define GADVR_PIN_MSB     4
`define GADVR_AUD_LEN     7
`define GADVR_AUD_TX      6
`define GADVR_ALN_BO      7
`define GADVR_ALN_LIM     0
`define GADVR_DG_NG       7
`define GADVR_DIAG_CLOCK_SELECT      6
`define GADVR_DG_COMB     5
// Pin function codes
`define GADVR_PF_ALIGN    3'h0
`define GADVR_PF_OFF      3'h2
`define GADVR_PF_GPI      3'h3
`define GADVR_PF_GPO      3'h4
// Diagnostic codes
`define GADVR_DG_ZERO     5'h00
`define GADVR_DG_DC_LAST  5'h0A
`define GADVR_DG_FS4      5'h0B
`define GADVR_DG_FS6      5'h0C
`define GADVR_DG_SINE     5'h0D
`define GADVR_DG_PROG     5'h0E
// Slot spacing of the alignment group, volume limit and DC level step
`define GADVR_SLOT_STEP   6'h03
`define GADVR_VOL_MAX     8'hC8
`define GADVR_DC_STEP_DB  5'h06
`endif

//--- include/gadvr_pkg.sv
// Types shared by the alignment/volume register bank
package gadvr_pkg;
  // What the diagnostic generator produces
  typedef enum logic [2:0] {
    GADVR_DIAG_ZERO,
    GADVR_DIAG_DC,
    GADVR_DIAG_FS4,
    GADVR_DIAG_FS6,
    GADVR_DIAG_SINE,
    GADVR_DIAG_PROG
  } gadvr_diag_t;
endpackage : gadvr_pkg

//--- src/gadvr_regs.sv
// Register bank for pin function, audio slot, gain alignment, diagnostics and volume
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "gadvr_params.svh"

// Overview of operation
// - Pin function code selects align, off, GPI, GPO
// - Slot length bit picks 16 or 24 bits
// - Audio transmitted only while transmit enable set
// - Six-bit audio slot field, reset 12h
// - Brownout alignment only when its enable set
// - Six-bit alignment start slot, reset 6h
// - Limiter alignment only when its enable set
// - Include bit n adds slot start plus 3n
// - Noise gate plus bit gives improved alignment
// - Diag clock internal when clear, external when set
// - Attenuation summed when clear, maximum when set
// - Diag selector picks zero, DC levels, tones, sine
// - Code 0Eh gives programmable DC; rest reserved
// - Volume 0.5 dB steps, above C8h mutes
module gadvr_regs (
  input  wire logic                       clk,               // 100 MHz clock
  input  wire logic                       rst_b,             // Async reset, active low
  input  wire logic [7:0]                 address,           // Avalon byte address
  input  wire logic                       read,              // Avalon read
  input  wire logic                       write,             // Avalon write
  input  wire logic [31:0]                writedata,         // Avalon write data
  input  wire logic [3:0]                 byteenable,        // Avalon byte enables
  output logic      [31:0]                readdata,          // Avalon read data
  output logic                            waitrequest,       // Avalon wait request
  input  wire logic                       noise_gate_en,     // Noise gate active
  input  wire logic [7:0]                 brownout_atten,    // Brownout attenuation, dB
  input  wire logic [7:0]                 limiter_atten,     // Limiter attenuation, dB
  output logic                            pin_gain_align,    // Pin carries gain alignment
  output logic                            pin_buf_off,       // Pin buffers disabled
  output logic                            pin_gpi,           // Pin is general input
  output logic                            pin_gpo,           // Pin is general output
  output logic                            audio_slot_24,     // Audio slot 24 bits wide
  output logic                            audio_tx_en,       // Audio transmit enable
  output logic      [5:0]                 audio_slot,        // Audio output slot
  output logic                            brownout_align_on, // Brownout alignment active
  output logic                            limiter_align_on,  // Limiter alignment active
  output logic      [5:0]                 align_start,       // Alignment start slot
  output logic      [47:0]                group_slots,       // Slot of member n at [6n+:6]
  output logic      [7:0]                 group_member,      // Member n is in the group
  output logic                            ng_align_active,   // Improved alignment in use
  output logic                            diag_clk_ext,      // Diag runs on bit clock/sync
  output gadvr_pkg::gadvr_diag_t          diag_kind,         // Diagnostic signal kind
  output logic                            diag_dc_neg,       // Fixed DC level negative
  output logic      [4:0]                 diag_dc_db,        // Fixed DC level, -dBFS
  output logic      [8:0]                 total_atten,       // Combined attenuation, dB
  output logic      [7:0]                 vol_halfdb,        // Volume attenuation, 0.5 dB
  output logic                            vol_mute           // Output muted
);
  import gadvr_pkg::*;

  // Stored fields; reserved bits have no storage at all
  logic [2:0]  pin_fn_r;    // Pin function field
  logic [7:0]  audio_r;     // Audio slot configuration
  logic [7:0]  align_r;     // Alignment configuration
  logic [7:0]  slots_r;     // Slot include bits
  logic [7:0]  diag_r;      // Diagnostic configuration
  logic [7:0]  vol_r;       // Volume level
  logic        wait_r;      // Wait request flop
  logic [31:0] rdata_r;     // Read data flop
  logic [31:0] rdata_nxt;   // Read data to capture
  logic        wr_acc;      // Write taken at this edge
  logic        req_new;     // Request not yet answered

  // Address decode, shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
    hit = (a[7:2] == idx);
  endfunction : hit

  // Slot of group member n: start plus three per step, wrapping at 64
  function automatic logic [5:0] slot_of(input logic [5:0] start, input logic [2:0] n);
    logic [5:0] off;
    off = 6'({3'h0, n} * `GADVR_SLOT_STEP);
    slot_of = 6'(start + off);
  endfunction : slot_of

  // A write lands only at the edge where waitrequest is seen low
  assign wr_acc  = write && !wait_r && byteenable[0];
  assign req_new = (read || write) && wait_r;

  // Answer each request with exactly one low cycle of waitrequest
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !req_new;
    end
  end

  // Read mux; unmapped addresses and reserved bits read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit(address, `GADVR_IDX_PIN)) begin
      rdata_nxt[`GADVR_PIN_MSB:`GADVR_PIN_LSB] = pin_fn_r;
    end else if (hit(address, `GADVR_IDX_AUDIO)) begin
      rdata_nxt[7:0] = audio_r;
    end else if (hit(address, `GADVR_IDX_ALIGN)) begin
      rdata_nxt[7:0] = align_r;
    end else if (hit(address, `GADVR_IDX_SLOTS)) begin
      rdata_nxt[7:0] = slots_r;
    end else if (hit(address, `GADVR_IDX_DIAG)) begin
      rdata_nxt[7:0] = diag_r;
    end else if (hit(address, `GADVR_IDX_VOL)) begin
      rdata_nxt[7:0] = vol_r;
    end
  end

  // Read data captured as waitrequest drops for a read, held until next read answer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 32'h0000_0000;
    end else if (req_new && read) begin
      rdata_r <= rdata_nxt;
    end
  end

  // Pin function; only bits 4:2 are kept
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_fn_r <= `GADVR_RST_PIN;
    end else if (wr_acc && hit(address, `GADVR_IDX_PIN)) begin
      pin_fn_r <= writedata[`GADVR_PIN_MSB:`GADVR_PIN_LSB];
    end
  end

  // Audio slot configuration
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      audio_r <= `GADVR_RST_AUDIO;
    end else if (wr_acc && hit(address, `GADVR_IDX_AUDIO)) begin
      audio_r <= writedata[7:0];
    end
  end

  // Alignment configuration: enables and start slot
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      align_r <= `GADVR_RST_ALIGN;
    end else if (wr_acc && hit(address, `GADVR_IDX_ALIGN)) begin
      align_r <= writedata[7:0];
    end
  end

  // Slot include bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slots_r <= `GADVR_RST_SLOTS;
    end else if (wr_acc && hit(address, `GADVR_IDX_SLOTS)) begin
      slots_r <= writedata[7:0];
    end
  end

  // Diagnostic configuration
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      diag_r <= `GADVR_RST_DIAG;
    end else if (wr_acc && hit(address, `GADVR_IDX_DIAG)) begin
      diag_r <= writedata[7:0];
    end
  end

  // Volume level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vol_r <= `GADVR_RST_VOL;
    end else if (wr_acc && hit(address, `GADVR_IDX_VOL)) begin
      vol_r <= writedata[7:0];
    end
  end

  // Pin function decode; reserved codes park the pin with buffers off,
  // the safest state when software loads a code with no meaning
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_gain_align <= 1'b1;
      pin_buf_off    <= 1'b0;
      pin_gpi        <= 1'b0;
      pin_gpo        <= 1'b0;
    end else begin
      pin_gain_align <= (pin_fn_r == `GADVR_PF_ALIGN);
      pin_gpi        <= (pin_fn_r == `GADVR_PF_GPI);
      pin_gpo        <= (pin_fn_r == `GADVR_PF_GPO);
      pin_buf_off    <= !((pin_fn_r == `GADVR_PF_ALIGN) || (pin_fn_r == `GADVR_PF_GPI)
                          || (pin_fn_r == `GADVR_PF_GPO));
    end
  end

  // Audio output placement in the serial frame
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      audio_slot_24 <= 1'b0;
      audio_tx_en   <= 1'b0;
      audio_slot    <= 6'(`GADVR_RST_AUDIO);
    end else begin
      audio_slot_24 <= audio_r[`GADVR_AUD_LEN];
      audio_tx_en   <= audio_r[`GADVR_AUD_TX];
      audio_slot    <= audio_r[5:0];
    end
  end

  // Alignment enables and group membership
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      brownout_align_on <= 1'b0;
      limiter_align_on  <= 1'b0;
      align_start       <= 6'h06;
      group_slots       <= 48'h0;
      group_member      <= 8'h00;
    end else begin
      brownout_align_on <= align_r[`GADVR_ALN_BO];
      limiter_align_on  <= align_r[`GADVR_ALN_LIM];
      align_start       <= align_r[6:1];
      for (int n = 0; n < 8; n++) begin
        group_slots[n*6 +: 6] <= slot_of(align_r[6:1], 3'(n));
      end
      // Members count only while limiter alignment runs
      group_member <= align_r[`GADVR_ALN_LIM] ? slots_r : 8'h00;
    end
  end

  // Improved alignment needs both the noise gate and its enable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ng_align_active <= 1'b0;
      diag_clk_ext    <= 1'b0;
    end else begin
      ng_align_active <= noise_gate_en && diag_r[`GADVR_DG_NG];
      diag_clk_ext    <= diag_r[`GADVR_DIAG_CLOCK_SELECT];
    end
  end

  // Attenuation combine; the sum keeps a ninth bit so it cannot wrap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      total_atten <= 9'h000;
    end else if (diag_r[`GADVR_DG_COMB]) begin
      total_atten <= {1'b0, (brownout_atten > limiter_atten) ? brownout_atten
                                                              : limiter_atten};
    end else begin
      total_atten <= {1'b0, brownout_atten} + {1'b0, limiter_atten};
    end
  end

  // Diagnostic signal decode; reserved codes fall back to silence
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      diag_kind   <= GADVR_DIAG_SINE;
      diag_dc_neg <= 1'b0;
      diag_dc_db  <= 5'h00;
    end else begin
      // Pairs of codes share a level: 01/02 at 6 dB up to 09/0A at 30 dB
      diag_dc_db  <= 5'((diag_r[4:0] + 5'h01) >> 1) * `GADVR_DC_STEP_DB;
      diag_dc_neg <= (diag_r[4:0] != 5'h01);
      if (diag_r[4:0] == `GADVR_DG_ZERO) begin
        diag_kind <= GADVR_DIAG_ZERO;
      end else if (diag_r[4:0] <= `GADVR_DG_DC_LAST) begin
        diag_kind <= GADVR_DIAG_DC;
      end else if (diag_r[4:0] == `GADVR_DG_FS4) begin
        diag_kind <= GADVR_DIAG_FS4;
      end else if (diag_r[4:0] == `GADVR_DG_FS6) begin
        diag_kind <= GADVR_DIAG_FS6;
      end else if (diag_r[4:0] == `GADVR_DG_SINE) begin
        diag_kind <= GADVR_DIAG_SINE;
      end else if (diag_r[4:0] == `GADVR_DG_PROG) begin
        diag_kind <= GADVR_DIAG_PROG;
      end else begin
        diag_kind <= GADVR_DIAG_ZERO;
      end
    end
  end

  // Volume: steps pass through, anything past the floor mutes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vol_halfdb <= 8'h00;
      vol_mute   <= 1'b0;
    end else begin
      vol_halfdb <= vol_r;
      vol_mute   <= (vol_r > `GADVR_VOL_MAX);
    end
  end

  assign readdata    = rdata_r;
  assign waitrequest = wait_r;

  // Checks on the bus answer and on register to output paths
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Accepted write to a given index
  sequence s_wr(logic [5:0] idx);
    write && !wait_r && byteenable[0] && hit(address, idx);
  endsequence

  // Output settles two edges after the write is taken
  sequence s_settle;
    ##2 1'b1;
  endsequence

  property p_answer;
    (read || write) && wait_r |=> !wait_r ##1 wait_r;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer not one cycle");

  property p_pin_fn;
    s_wr(`GADVR_IDX_PIN) ##0 (writedata[4:2] == `GADVR_PF_GPO) |-> s_settle ##0
      (pin_gpo && !pin_gpi && !pin_gain_align && !pin_buf_off);
  endproperty
  a_pin_fn: assert property (p_pin_fn) else $error("pin function decode wrong");

  property p_slot_len;
    s_wr(`GADVR_IDX_AUDIO) |-> s_settle ##0 (audio_slot_24 == $past(writedata[7], 2));
  endproperty
  a_slot_len: assert property (p_slot_len) else $error("slot length wrong");

  property p_tx_en;
    s_wr(`GADVR_IDX_AUDIO) ##0 !writedata[6] |-> s_settle ##0 !audio_tx_en;
  endproperty
  a_tx_en: assert property (p_tx_en) else $error("audio sent while disabled");

  property p_audio_slot;
    s_wr(`GADVR_IDX_AUDIO) |-> s_settle ##0 (audio_slot == $past(writedata[5:0], 2));
  endproperty
  a_audio_slot: assert property (p_audio_slot) else $error("audio slot wrong");

  property p_group;
    s_wr(`GADVR_IDX_ALIGN) |-> s_settle ##0
      (group_slots[47:42] == 6'($past(writedata[6:1], 2) + 6'h15));
  endproperty
  a_group: assert property (p_group) else $error("member 7 slot wrong");

  property p_lim_en;
    s_wr(`GADVR_IDX_ALIGN) ##0 !writedata[0] |-> s_settle ##0
      (!limiter_align_on && group_member == 8'h00);
  endproperty
  a_lim_en: assert property (p_lim_en) else $error("limiter alignment not off");

  // Mode bit taken from the same cycle as the inputs, as the flop saw them
  property p_combine;
    1'b1 |=> (total_atten == ($past(diag_r[5])
      ? {1'b0, ($past(brownout_atten) > $past(limiter_atten)) ? $past(brownout_atten)
                                                              : $past(limiter_atten)}
      : {1'b0, $past(brownout_atten)} + {1'b0, $past(limiter_atten)}));
  endproperty
  a_combine: assert property (p_combine) else $error("attenuation combine wrong");

  property p_mute;
    s_wr(`GADVR_IDX_VOL) ##0 (writedata[7:0] > 8'hC8) |-> s_settle ##0 vol_mute;
  endproperty
  a_mute: assert property (p_mute) else $error("volume above floor not muted");

  property p_reserved;
    !wait_r && read && hit(address, `GADVR_IDX_PIN) |->
      (readdata[7:5] == 3'h0 && readdata[1:0] == 2'h0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

endmodule : gadvr_regs
`default_nettype wire

//--- testbench/gadvr_regs_tb.sv
// Self-checking bench for the alignment/volume register bank over Avalon-MM
`timescale 1ns/100ps
`default_nettype none
`include "gadvr_params.svh"

module gadvr_regs_tb;
  import gadvr_pkg::*;

  logic                 clk;            // 100 MHz clock
  logic                 rst_b;          // Async reset, active low
  logic [7:0]           address;        // Bus byte address
  logic                 read;           // Bus read
  logic                 write;          // Bus write
  logic [31:0]          writedata;      // Bus write data
  logic [3:0]           byteenable;     // Bus byte enables
  logic [31:0]          readdata;       // Bus read data
  logic                 waitrequest;    // Bus wait request
  logic                 noise_gate_en;  // Noise gate input
  logic [7:0]           brownout_atten; // Brownout attenuation input
  logic [7:0]           limiter_atten;  // Limiter attenuation input
  logic                 pin_gain_align, pin_buf_off, pin_gpi, pin_gpo;
  logic                 audio_slot_24, audio_tx_en, brownout_align_on, limiter_align_on;
  logic [5:0]           audio_slot, align_start;
  logic [47:0]          group_slots;
  logic [7:0]           group_member, vol_halfdb;
  logic                 ng_align_active, diag_clk_ext, diag_dc_neg, vol_mute;
  gadvr_diag_t          diag_kind;
  logic [4:0]           diag_dc_db;
  logic [8:0]           total_atten;
  int                   errors;         // Mismatch count
  int                   cmp_count;      // Comparison count

  // Byte addresses are four times the register index
  localparam logic [7:0] ADR [6] = '{{`GADVR_IDX_PIN, 2'b00}, {`GADVR_IDX_AUDIO, 2'b00},
    {`GADVR_IDX_ALIGN, 2'b00}, {`GADVR_IDX_SLOTS, 2'b00}, {`GADVR_IDX_DIAG, 2'b00},
    {`GADVR_IDX_VOL, 2'b00}};
  localparam logic [7:0] RSTV [6] = '{8'h00, 8'h12, 8'h0C, 8'h00, 8'h0D, 8'h00};
  localparam logic [7:0] MSK [6] = '{8'h1C, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  // Fixed DC level in dB below full scale for codes 00h to 0Ah
  localparam logic [4:0] DCDB [11] = '{5'h00, 5'h06, 5'h06, 5'h0C, 5'h0C, 5'h12, 5'h12,
    5'h18, 5'h18, 5'h1E, 5'h1E};

  gadvr_regs gadvr_regs_inst (
    .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .noise_gate_en(noise_gate_en),
    .brownout_atten(brownout_atten), .limiter_atten(limiter_atten),
    .pin_gain_align(pin_gain_align), .pin_buf_off(pin_buf_off), .pin_gpi(pin_gpi),
    .pin_gpo(pin_gpo), .audio_slot_24(audio_slot_24), .audio_tx_en(audio_tx_en),
    .audio_slot(audio_slot), .brownout_align_on(brownout_align_on),
    .limiter_align_on(limiter_align_on), .align_start(align_start),
    .group_slots(group_slots), .group_member(group_member),
    .ng_align_active(ng_align_active), .diag_clk_ext(diag_clk_ext), .diag_kind(diag_kind),
    .diag_dc_neg(diag_dc_neg), .diag_dc_db(diag_dc_db), .total_atten(total_atten),
    .vol_halfdb(vol_halfdb), .vol_mute(vol_mute));

  // Free-running clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Verdict and end of run
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Case-equality compare, counted
  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One bus transfer; held until waitrequest is seen low at a rising edge
  task automatic bus_cycle(input logic wr, input logic [7:0] a, input logic [7:0] d,
                           input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge clk);
    address    <= a;
    writedata  <= {24'hA5A5A5, d}; // Upper lanes junk, must be ignored
    byteenable <= be;
    write      <= wr;
    read       <= ~wr;
    n = 0;
    // Waitrequest and read data are read at each rising edge, before it updates them
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) begin
      errors++;
      $display("[ERR] bus answer expected 0 seen %b", waitrequest);
      end_of_test();
    end
    q = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask : bus_cycle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus_cycle(1'b1, a, d, 4'h1, q);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus_cycle(1'b0, a, 8'h00, 4'h1, q);
    chk(what, 48'(q), 48'(exp));
  endtask : rd_chk

  // Outputs follow a write two edges after it lands
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask : settle

  // Slot n of the group is start plus 3n, wrapping at 64
  function automatic logic [47:0] slots_of(input logic [5:0] s);
    logic [47:0] r;
    for (int n = 0; n < 8; n++) r[6*n +: 6] = s + 6'(3 * n);
    return r;
  endfunction : slots_of

  // Expected generator kind for a selector code
  function automatic gadvr_diag_t kind_of(input logic [4:0] c);
    if (c == 5'h00 || c > 5'h0E) return GADVR_DIAG_ZERO;
    if (c <= 5'h0A) return GADVR_DIAG_DC;
    if (c == 5'h0B) return GADVR_DIAG_FS4;
    if (c == 5'h0C) return GADVR_DIAG_FS6;
    if (c == 5'h0D) return GADVR_DIAG_SINE;
    return GADVR_DIAG_PROG;
  endfunction : kind_of

  // Main sequence
  initial begin
    logic [31:0] q;
    logic [4:0]  cv;
    logic [8:0]  sum;
    rst_b = 1'b0; address = 8'h00; read = 1'b0; write = 1'b0; writedata = 32'h0;
    byteenable = 4'h0; noise_gate_en = 1'b0; brownout_atten = 8'h00; limiter_atten = 8'h00;
    errors = 0; cmp_count = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    settle();

    // Reset state at registers and outputs
    for (int i = 0; i < 6; i++) rd_chk("reset value", ADR[i], RSTV[i]);
    chk("pin align at reset", 48'(pin_gain_align), 48'h1);
    chk("audio slot at reset", 48'(audio_slot), 48'h12);
    chk("start slot at reset", 48'(align_start), 48'h06);
    chk("group at reset", group_slots, slots_of(6'h06));
    chk("diag kind at reset", 48'(diag_kind), 48'(GADVR_DIAG_SINE));
    $display("test reset done");

    // Read/write, reserved bits, ignored lanes, unmapped places
    for (int i = 0; i < 6; i++) begin
      wr(ADR[i], 8'hFF);
      rd_chk("readback", ADR[i], MSK[i]);
    end
    bus_cycle(1'b1, ADR[5], 8'h55, 4'h0, q);
    rd_chk("lane0 disabled write", ADR[5], 8'hFF);
    wr(8'h6C, 8'h77);
    rd_chk("unmapped", 8'h6C, 8'h00);
    rd_chk("unmapped below", 8'h50, 8'h00);
    $display("test access done");

    // Every pin function code, reserved bits written high
    for (int c = 0; c < 8; c++) begin
      wr(ADR[0], 8'hE3 | 8'(c << 2));
      settle();
      chk("pin function", 48'({pin_gain_align, pin_buf_off, pin_gpi, pin_gpo}),
          48'({c == 0, c == 1 || c == 2 || c > 4, c == 3, c == 4}));
    end
    $display("test pin done");

    // Audio slot length, transmit enable and slot field
    wr(ADR[1], 8'hC5);
    settle();
    chk("audio 24/tx/slot", 48'({audio_slot_24, audio_tx_en, audio_slot}), 48'h0C5);
    wr(ADR[1], 8'h3F);
    settle();
    chk("audio 16/off/slot", 48'({audio_slot_24, audio_tx_en, audio_slot}), 48'h03F);
    $display("test audio done");

    // Alignment group with wrapping start slot, then with both enables clear
    wr(ADR[3], 8'hA5);
    wr(ADR[2], 8'hFF);
    settle();
    chk("align enables", 48'({brownout_align_on, limiter_align_on}), 48'h3);
    chk("start slot", 48'(align_start), 48'h3F);
    chk("group slots wrap", group_slots, slots_of(6'h3F));
    chk("group members", 48'(group_member), 48'hA5);
    wr(ADR[2], 8'h14);
    settle();
    chk("align disabled", 48'({brownout_align_on, limiter_align_on}), 48'h0);
    chk("group slots", group_slots, slots_of(6'h0A));
    chk("members masked", 48'(group_member), 48'h00);
    $display("test alignment done");

    // Every selector code with clock, combine and noise-gate bits varied
    for (int c = 0; c < 32; c++) begin
      cv = 5'(c);
      @(posedge clk);
      noise_gate_en  <= cv[3];
      brownout_atten <= 8'(c * 9);
      limiter_atten  <= 8'(255 - c * 4);
      wr(ADR[4], {cv[0], cv[1], cv[2], cv});
      settle();
      chk("diag kind", 48'(diag_kind), 48'(kind_of(cv)));
      chk("diag clock", 48'(diag_clk_ext), 48'(cv[1]));
      chk("ng align", 48'(ng_align_active), 48'(cv[3] & cv[0]));
      sum = 9'(brownout_atten) + 9'(limiter_atten);
      if (cv[2]) begin
        sum = (brownout_atten > limiter_atten) ? 9'(brownout_atten) : 9'(limiter_atten);
      end
      chk("total atten", 48'(total_atten), 48'(sum));
      if (cv >= 5'h01 && cv <= 5'h0A) begin
        chk("dc level", 48'({diag_dc_neg, diag_dc_db}),
            48'({cv != 5'h01, DCDB[c]}));
      end
    end
    $display("test diag done");

    // Volume steps, last step and mute values
    foreach (RSTV[i]) begin
      q[7:0] = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'hC8 : (i == 3) ? 8'hC9 :
               (i == 4) ? 8'hFF : 8'h64;
      wr(ADR[5], q[7:0]);
      settle();
      chk("volume", 48'({vol_mute, vol_halfdb}), 48'({q[7:0] > 8'hC8, q[7:0]}));
    end
    $display("test volume done");
    end_of_test();
  end
endmodule : gadvr_regs_tb
`default_nettype wire
